// >>> logic/egress_sched_pkg.sv
// Purpose: Shared constants for the port 1 egress queue ratio scheduler.
// Assumes: APB with 32-bit data and 12-bit byte addresses.
// Notes: Printed register offsets are word indexes; byte address is four
//        times the index.

package egress_sched_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned RATIO_W = 7;
   localparam int unsigned NUM_QUEUES = 4;

   // ==========================================================
   // Register indexes and byte addresses
   localparam logic [11:0] IDX_HIGH_QUEUES = 12'h0c8;
   localparam logic [11:0] IDX_LOW_QUEUES = 12'h0ca;
   localparam logic [11:0] IDX_SCHED_STATUS = 12'h0e0;
   localparam logic [11:0] ADDR_HIGH_QUEUES = IDX_HIGH_QUEUES << 2;
   localparam logic [11:0] ADDR_LOW_QUEUES = IDX_LOW_QUEUES << 2;
   localparam logic [11:0] ADDR_SCHED_STATUS = IDX_SCHED_STATUS << 2;

   // ==========================================================
   // Field positions inside a 16-bit control word
   localparam int unsigned UPPER_MODE_BIT = 15;
   localparam int unsigned UPPER_RATIO_LSB = 8;
   localparam int unsigned LOWER_MODE_BIT = 7;
   localparam int unsigned LOWER_RATIO_LSB = 0;

   // ==========================================================
   // Values after reset
   localparam logic Q0_MODE_RST = 1'b1;
   localparam logic Q1_MODE_RST = 1'b1;
   localparam logic Q2_MODE_RST = 1'b1;
   localparam logic Q3_MODE_RST = 1'b1;
   localparam logic [6:0] Q0_RATIO_RST = 7'h01;
   localparam logic [6:0] Q1_RATIO_RST = 7'h02;
   localparam logic [6:0] Q2_RATIO_RST = 7'h04;
   localparam logic [6:0] Q3_RATIO_RST = 7'h08;

   // ==========================================================
   // Scheduling period in pclk cycles
   localparam int unsigned PERIOD_CYCLES_DEF = 1024;

endpackage : egress_sched_pkg

// >>> logic/ratio_credit_counter.sv
// Purpose: Packet credit counter for one egress queue in ratio mode.
// Assumes: Reload and consume are single-cycle strobes on pclk.
// Notes: A reload and a consume in one cycle leave limit minus one.

`timescale 1ns/1ps

module ratio_credit_counter #(
   parameter int unsigned ratio_width = 7
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic [ratio_width-1:0] reset_limit,
   input wire logic [ratio_width-1:0] limit,
   input wire logic reload,
   input wire logic consume,
   // State
   output logic [ratio_width-1:0] credit,
   output logic has_credit
);

   // ==========================================================
   // Parameter checks
   generate
      if (ratio_width < 1) begin : g_bad_width
         $error("ratio_width must be at least 1");
      end
   endgenerate

   // ==========================================================
   // Credit update
   logic [ratio_width-1:0] base;
   logic [ratio_width-1:0] next_credit;
   logic [ratio_width-1:0] reset_value;

   assign base = reload ? limit : credit;
   assign next_credit = (consume && (base != '0)) ?
                        base - 1'b1 : base;
   assign has_credit = (credit != '0);

   // The reset value is a parameter-like constant, so capture it once.
   logic loaded;

   assign reset_value = reset_limit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded <= 1'b0;
         credit <= '0;
      end else begin
         loaded <= 1'b1;
         credit <= loaded ? next_credit : reset_value;
      end
   end

endmodule : ratio_credit_counter

// >>> logic/egress_queue_ratio_scheduler.sv
// Purpose: Picks the next egress queue of port 1 by strict or ratio mode.
// Assumes: APB slave on pclk, zero wait states, 10 MHz clock.
// Notes: Queue 3 is highest priority, queue 0 lowest.
// What this block does
// - Strict queue 2 is emptied before lower queues, else ratio-limited.
// - Strict queue 3 sends all its packets first, else ratio-limited.
// - Strict queue 0 goes after all higher queues, else ratio-limited.
// - Strict queue 1 is emptied before queue 0, else ratio-limited.
// - High-queues bits 14 to 8 hold the queue 2 limit, reset 0x04.
// - High-queues bits 6 to 0 hold the queue 3 limit, reset 0x08.
// - Low-queues bits 14 to 8 hold the queue 0 limit, reset 0x01.
// - Low-queues bits 6 to 0 hold the queue 1 limit, reset 0x02.
//
// The implementer's own choice: the APB register port.

`timescale 1ns/1ps

module egress_queue_ratio_scheduler #(
   parameter int unsigned period_cycles =
      egress_sched_pkg::PERIOD_CYCLES_DEF,
   parameter int unsigned ratio_width = egress_sched_pkg::RATIO_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Queue side
   input wire logic [3:0] queue_pending,
   input wire logic tx_ready,
   output logic tx_grant,
   output logic [1:0] tx_queue,
   output logic period_start
);

   // ==========================================================
   // Parameter checks
   generate
      if (period_cycles < 2) begin : g_bad_period
         $error("period_cycles must be at least 2");
      end
      if (ratio_width != egress_sched_pkg::RATIO_W) begin : g_bad_width
         $error("ratio_width must match the 7-bit ratio fields");
      end
      // The period counter is 16 bits wide.
      if (period_cycles > 65536) begin : g_long_period
         $error("period_cycles must not exceed 65536");
      end
   endgenerate

   localparam logic [15:0] PERIOD_LAST = 16'(period_cycles - 1);

   // ==========================================================
   // Helper functions
   function automatic logic [15:0] pack_word(
      input logic upper_mode,
      input logic [6:0] upper_ratio,
      input logic lower_mode,
      input logic [6:0] lower_ratio
   );
      logic [15:0] w;
      w = 16'h0000;
      w[egress_sched_pkg::UPPER_MODE_BIT] = upper_mode;
      w[egress_sched_pkg::UPPER_RATIO_LSB +: 7] = upper_ratio;
      w[egress_sched_pkg::LOWER_MODE_BIT] = lower_mode;
      w[egress_sched_pkg::LOWER_RATIO_LSB +: 7] = lower_ratio;
      return w;
   endfunction : pack_word

   function automatic logic [15:0] merge_lanes(
      input logic [15:0] old_word,
      input logic [15:0] new_word,
      input logic [1:0] strb
   );
      logic [15:0] w;
      w = old_word;
      if (strb[0]) begin
         w[7:0] = new_word[7:0];
      end
      if (strb[1]) begin
         w[15:8] = new_word[15:8];
      end
      return w;
   endfunction : merge_lanes

   // True when a ratio field lets its queue send at all.
   function automatic logic limit_set(
      input logic [6:0] ratio
   );
      return ratio != 7'h00;
   endfunction : limit_set

   // ==========================================================
   // Configuration state
   logic [3:0] ratio_mode;
   logic [6:0] ratio_q0;
   logic [6:0] ratio_q1;
   logic [6:0] ratio_q2;
   logic [6:0] ratio_q3;

   logic [15:0] high_word;
   logic [15:0] low_word;

   assign high_word = pack_word(ratio_mode[2], ratio_q2,
                                ratio_mode[3], ratio_q3);
   assign low_word = pack_word(ratio_mode[0], ratio_q0,
                               ratio_mode[1], ratio_q1);

   // ==========================================================
   // APB decode
   logic setup_phase;
   logic access_phase;
   logic hit_high;
   logic hit_low;
   logic hit_status;
   logic addr_mapped;
   logic write_high;
   logic write_low;
   logic [15:0] next_high;
   logic [15:0] next_low;

   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign hit_high = (paddr == egress_sched_pkg::ADDR_HIGH_QUEUES);
   assign hit_low = (paddr == egress_sched_pkg::ADDR_LOW_QUEUES);
   assign hit_status = (paddr == egress_sched_pkg::ADDR_SCHED_STATUS);
   assign addr_mapped = hit_high || hit_low || hit_status;
   assign write_high = access_phase && pwrite && hit_high;
   assign write_low = access_phase && pwrite && hit_low;
   assign next_high = merge_lanes(high_word, pwdata[15:0], pstrb[1:0]);
   assign next_low = merge_lanes(low_word, pwdata[15:0], pstrb[1:0]);

   // Zero wait states keep the scheduler's view of settings simple.
   assign pready = 1'b1;
   assign pslverr = access_phase && !addr_mapped;

   // ==========================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ratio_mode[0] <= egress_sched_pkg::Q0_MODE_RST;
         ratio_mode[1] <= egress_sched_pkg::Q1_MODE_RST;
         ratio_mode[2] <= egress_sched_pkg::Q2_MODE_RST;
         ratio_mode[3] <= egress_sched_pkg::Q3_MODE_RST;
         ratio_q0 <= egress_sched_pkg::Q0_RATIO_RST;
         ratio_q1 <= egress_sched_pkg::Q1_RATIO_RST;
         ratio_q2 <= egress_sched_pkg::Q2_RATIO_RST;
         ratio_q3 <= egress_sched_pkg::Q3_RATIO_RST;
      end else begin
         if (write_high) begin
            ratio_mode[2] <=
               next_high[egress_sched_pkg::UPPER_MODE_BIT];
            ratio_q2 <=
               next_high[egress_sched_pkg::UPPER_RATIO_LSB +: 7];
            ratio_mode[3] <=
               next_high[egress_sched_pkg::LOWER_MODE_BIT];
            ratio_q3 <=
               next_high[egress_sched_pkg::LOWER_RATIO_LSB +: 7];
         end
         if (write_low) begin
            ratio_mode[0] <=
               next_low[egress_sched_pkg::UPPER_MODE_BIT];
            ratio_q0 <=
               next_low[egress_sched_pkg::UPPER_RATIO_LSB +: 7];
            ratio_mode[1] <=
               next_low[egress_sched_pkg::LOWER_MODE_BIT];
            ratio_q1 <=
               next_low[egress_sched_pkg::LOWER_RATIO_LSB +: 7];
         end
      end
   end

   // ==========================================================
   // Credit counters
   logic [6:0] limit [4];
   logic [6:0] limit_rst [4];
   logic [6:0] credit [4];
   logic [3:0] has_credit;
   logic [3:0] consume;
   logic reload;

   assign limit[0] = ratio_q0;
   assign limit[1] = ratio_q1;
   assign limit[2] = ratio_q2;
   assign limit[3] = ratio_q3;
   assign limit_rst[0] = egress_sched_pkg::Q0_RATIO_RST;
   assign limit_rst[1] = egress_sched_pkg::Q1_RATIO_RST;
   assign limit_rst[2] = egress_sched_pkg::Q2_RATIO_RST;
   assign limit_rst[3] = egress_sched_pkg::Q3_RATIO_RST;

   // Every counter shares the one reload strobe, so all queues refill together.
   generate
      for (genvar q = 0; q < 4; q++) begin : g_credit
         ratio_credit_counter #(
            .ratio_width(ratio_width)
         ) i_ratio_credit_counter (
            .pclk(pclk),
            .presetn(presetn),
            .reset_limit(limit_rst[q]),
            .limit(limit[q]),
            .reload(reload),
            .consume(consume[q]),
            .credit(credit[q]),
            .has_credit(has_credit[q])
         );
      end
   endgenerate

   // ==========================================================
   // Queue selection
   logic [3:0] eligible;
   logic any_eligible;
   logic [1:0] pick;
   logic issue;
   logic stalled;
   logic [3:0] refillable;

   // A strict queue is always eligible while it holds packets, so it
   // shadows every lower queue until it runs dry.
   assign eligible = queue_pending &
                     (~ratio_mode | has_credit);
   assign any_eligible = |eligible;
   assign pick = eligible[3] ? 2'd3 :
                 eligible[2] ? 2'd2 :
                 eligible[1] ? 2'd1 : 2'd0;
   // One grant at a time; issue is blocked while tx_grant is high, so grants are at least two cycles apart.
   assign issue = tx_ready && any_eligible && !tx_grant;
   assign consume = (issue ? (4'b0001 << pick) : 4'b0000) &
                    ratio_mode;

   // ==========================================================
   // Period timer
   logic [15:0] period_count;
   logic timer_done;

   assign timer_done = (period_count == PERIOD_LAST);
   // Work-conserving: if every pending queue is out of credit, start the
   // next period now rather than leave the port idle.
   // A zero ratio parks its queue; reloading for it would only spin the
   // timer every cycle, so such a queue never forces an early period.
   assign refillable[0] = limit_set(ratio_q0);
   assign refillable[1] = limit_set(ratio_q1);
   assign refillable[2] = limit_set(ratio_q2);
   assign refillable[3] = limit_set(ratio_q3);
   assign stalled = (|(queue_pending & ratio_mode & refillable)) &&
                    !any_eligible;
   assign reload = timer_done || stalled;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_count <= 16'h0000;
         period_start <= 1'b0;
      end else begin
         period_count <= reload ? 16'h0000 : period_count + 16'h0001;
         period_start <= reload;
      end
   end

   // ==========================================================
   // Grant output
   // The queue number stays until the next grant, so the MAC may read it late.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_grant <= 1'b0;
         tx_queue <= 2'd0;
      end else begin
         tx_grant <= issue;
         if (issue) begin
            tx_queue <= pick;
         end
      end
   end

   // ==========================================================
   // Read data
   logic [31:0] status_word;
   logic [31:0] read_mux;

   assign status_word = {1'b0, credit[3], 1'b0, credit[2],
                         1'b0, credit[1], 1'b0, credit[0]};
   assign read_mux = hit_high ? {16'h0000, high_word} :
                     hit_low ? {16'h0000, low_word} :
                     hit_status ? status_word : 32'h0000_0000;

   // Captured in the setup cycle so that the access cycle shows a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata <= read_mux;
      end
   end

endmodule : egress_queue_ratio_scheduler

// >>> verif/egress_sched_assertions.sv
// Purpose: Port-level timing checks for the egress queue scheduler.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Queue order depends on register state, so the bench judges it.
`timescale 1ns/1ps
module egress_sched_checker #(
   parameter int unsigned period_cycles = 1024
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Queue side
   input wire logic [3:0] queue_pending,
   input wire logic tx_ready,
   input wire logic tx_grant,
   input wire logic [1:0] tx_queue,
   input wire logic period_start
);
   // ====================
   // Helper logic
   int unsigned since_start;
   logic [3:0] pend_q;
   logic ready_q;
   wire logic mapped = paddr == egress_sched_pkg::ADDR_HIGH_QUEUES ||
      paddr == egress_sched_pkg::ADDR_LOW_QUEUES ||
      paddr == egress_sched_pkg::ADDR_SCHED_STATUS;
   wire logic is_status = paddr == egress_sched_pkg::ADDR_SCHED_STATUS;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_start <= 0;
         pend_q <= 4'h0;
         ready_q <= 1'b0;
      end else begin
         since_start <= period_start ? 0 : since_start + 1;
         pend_q <= queue_pending;
         ready_q <= tx_ready;
      end
   end
   // ====================
   // Properties
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_read;
      psel && penable && !pwrite && !is_status;
   endsequence
   property p_grant_pulse;
      tx_grant |=> !tx_grant;
   endproperty
   property p_grant_cause;
      tx_grant |-> ready_q && pend_q[tx_queue];
   endproperty
   property p_no_ready;
      !tx_ready |=> !tx_grant;
   endproperty
   property p_queue_hold;
      !tx_grant |-> $stable(tx_queue);
   endproperty
   property p_period_pulse;
      period_start |=> !period_start;
   endproperty
   property p_period_bound;
      since_start < period_cycles + 2;
   endproperty
   property p_err_unmapped;
      s_access ##0 !mapped |-> pslverr && pready;
   endproperty
   property p_ok_mapped;
      s_access ##0 mapped |-> !pslverr && pready;
   endproperty
   property p_upper_zero;
      s_read |-> prdata[31:16] == 16'h0000;
   endproperty
   a_grant_pulse: assert property (p_grant_pulse)
      else $error("grant lasted more than one cycle");
   a_grant_cause: assert property (p_grant_cause)
      else $error("grant without ready or pending queue");
   a_no_ready: assert property (p_no_ready)
      else $error("grant while transmit not ready");
   a_queue_hold: assert property (p_queue_hold)
      else $error("queue number moved without a grant");
   a_period_pulse: assert property (p_period_pulse)
      else $error("period start lasted more than one cycle");
   a_period_bound: assert property (p_period_bound)
      else $error("scheduling period overran its length");
   a_err_unmapped: assert property (p_err_unmapped)
      else $error("unmapped access not flagged");
   a_ok_mapped: assert property (p_ok_mapped)
      else $error("mapped access flagged as error");
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper half of control word not zero");
endmodule : egress_sched_checker
bind egress_queue_ratio_scheduler egress_sched_checker #(
   .period_cycles(period_cycles)
) i_egress_sched_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .queue_pending(queue_pending),
   .tx_ready(tx_ready), .tx_grant(tx_grant), .tx_queue(tx_queue),
   .period_start(period_start)
);

// >>> verif/egress_queue_ratio_scheduler_test.sv
// Purpose: Self-checking bench for the egress queue scheduler.
// Assumes: Period shortened to 64 cycles so reloads come quickly.
// Notes: Grants are collected in order and matched to a packed list.
`timescale 1ns/1ps
module egress_queue_ratio_scheduler_test;
   // ====================
   // Signals
   localparam logic [11:0] hi = egress_sched_pkg::ADDR_HIGH_QUEUES;
   localparam logic [11:0] lo = egress_sched_pkg::ADDR_LOW_QUEUES;
   localparam logic [11:0] st = egress_sched_pkg::ADDR_SCHED_STATUS;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic tx_ready, tx_grant, period_start;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, queue_pending;
   logic [1:0] tx_queue;
   int n_mismatch, checks;
   egress_queue_ratio_scheduler #(.period_cycles(64))
      i_egress_queue_ratio_scheduler (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .queue_pending(queue_pending), .tx_ready(tx_ready),
      .tx_grant(tx_grant), .tx_queue(tx_queue),
      .period_start(period_start));
   // ====================
   // Shared tasks
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic timed_out(input string what);
      n_mismatch++;
      $display("mismatch %s expected answer seen timeout", what);
      finish_test();
   endtask : timed_out
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) timed_out("pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Stops traffic first, so no grant decided on old inputs leaks in.
   task automatic start_queues(input logic [3:0] pend, input logic per);
      int i;
      @(posedge pclk);
      tx_ready <= 1'b0;
      queue_pending <= pend;
      repeat (2) @(posedge pclk);
      for (i = 0; per && i < 80; i++) begin
         @(posedge pclk);
         #1;
         if (period_start === 1'b1) break;
      end
      if (i == 80) timed_out("period_start");
      @(posedge pclk);
      tx_ready <= 1'b1;
   endtask : start_queues
   task automatic grants(input logic [15:0] seq, input int n);
      int g, i;
      for (g = 0; g < n; g++) begin
         for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            #1;
            if (tx_grant === 1'b1) break;
         end
         if (i == 20) timed_out("tx_grant");
         cmp("tx_queue", {30'h0, seq[2*g +: 2]}, {30'h0, tx_queue});
      end
   endtask : grants
   // ====================
   // Scenarios
   task automatic reset_values;
      apb(1'b0, hi, 32'h0, 4'h0);
      cmp("high word", 32'h00008488, rd);
      apb(1'b0, lo, 32'h0, 4'h0);
      cmp("low word", 32'h00008182, rd);
      apb(1'b0, st, 32'h0, 4'h0);
      cmp("credits", 32'h08040201, rd);
      $display("test reset_values done");
   endtask : reset_values
   task automatic field_writes;
      apb(1'b1, hi, 32'h00001133, 4'h1);
      apb(1'b0, hi, 32'h0, 4'h0);
      cmp("high lane", 32'h00008433, rd);
      apb(1'b1, lo, 32'h00007f7f, 4'h3);
      apb(1'b0, lo, 32'h0, 4'h0);
      cmp("low word", 32'h00007f7f, rd);
      apb(1'b1, 12'h004, 32'h0000ffff, 4'hf);
      cmp("error", 32'h1, {31'h0, err});
      apb(1'b0, 12'h004, 32'h0, 4'h0);
      cmp("unmapped", 32'h1, {31'h0, err});
      cmp("unmapped data", 32'h0, rd);
      $display("test field_writes done");
   endtask : field_writes
   task automatic strict_order;
      apb(1'b1, hi, 32'h0, 4'h3);
      apb(1'b1, lo, 32'h0, 4'h3);
      start_queues(4'hf, 1'b0);
      grants(16'h00ff, 4);
      start_queues(4'h7, 1'b0);
      grants(16'h00aa, 4);
      start_queues(4'h3, 1'b0);
      grants(16'h0055, 4);
      start_queues(4'h1, 1'b0);
      grants(16'h0000, 4);
      $display("test strict_order done");
   endtask : strict_order
   task automatic ratio_counts;
      apb(1'b1, hi, 32'h00008283, 4'h3);
      apb(1'b1, lo, 32'h00008181, 4'h3);
      start_queues(4'hf, 1'b1);
      grants(16'hc6bf, 8);
      apb(1'b1, hi, 32'h00008280, 4'h3);
      apb(1'b1, lo, 32'h00008282, 4'h3);
      start_queues(4'hf, 1'b1);
      grants(16'ha05a, 8);
      start_queues(4'h8, 1'b1);
      repeat (8) begin
         @(posedge pclk);
         #1;
         cmp("parked grant", 32'h0, {31'h0, tx_grant});
      end
      $display("test ratio_counts done");
   endtask : ratio_counts
   // ====================
   // Clock and main sequence
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, tx_ready} = 5'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      queue_pending = 4'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      field_writes();
      strict_order();
      ratio_counts();
      finish_test();
   end
endmodule : egress_queue_ratio_scheduler_test
